// ===== verilog/mdc_consts.svh
// Constants for the multiplier/divider coprocessor
// Assumes inclusion by bare name from the design files
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH

// ****************************************
// Mode register layout
// ****************************************
`define MDC_MODE_W        7
`define MDC_OUT_MSB       6
`define MDC_OUT_LSB       4
`define MDC_OP_MSB        3
`define MDC_OP_LSB        0
`define MDC_MODE_RST      7'h00

// ****************************************
// Operation and output encodings
// ****************************************
`define MDC_OP_CLEAR      4'h0
`define MDC_OP_LOAD16     4'h1
`define MDC_OP_LOAD32     4'h2
`define MDC_OP_READ       4'h3
`define MDC_OP_UMUL       4'h4
`define MDC_OP_SMUL       4'h5
`define MDC_OP_SMAC       4'h7
`define MDC_OP_UDIV       4'h8
`define MDC_OP_SDIV       4'h9
`define MDC_OUT_LOW       3'h0
`define MDC_OUT_HIGH      3'h1

// ****************************************
// Widths, reset values and timing
// ****************************************
`define MDC_RES_RST       32'h0000_0000
`define MDC_DIV_STEPS     5'h10
`define MDC_STEP_RST      5'h00
`define MDC_STEP_ONE      5'h01
`define MDC_HALF_ZERO     16'h0000

`endif

// ===== verilog/mdc_pkg.sv
// Types for the multiplier/divider coprocessor
// Assumes mdc_consts.svh is compiled alongside
package mdc_pkg;

    // Top control states, Gray coded along idle-divide-fixup-done
    typedef enum logic [1:0] {
        MDC_IDLE  = 2'h0,
        MDC_DIV   = 2'h1,
        MDC_FIX   = 2'h3,
        MDC_DONE  = 2'h2
    } mdc_state_t;

endpackage : mdc_pkg

// ===== verilog/mdc_div_if.sv
// Interface between the coprocessor control and its divider
// Assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none

interface mdc_div_if;
    logic        start;
    logic [15:0] dividend;
    logic [15:0] divisor;
    logic        busy;
    logic        done;
    logic [15:0] quot;
    logic [15:0] rem;

    modport ctl (output start, dividend, divisor,
                 input busy, done, quot, rem);
    modport div (input start, dividend, divisor,
                 output busy, done, quot, rem);
endinterface : mdc_div_if

`default_nettype wire

// ===== verilog/mdc_divider.sv
// Unsigned restoring divider, one quotient bit per clock
// Assumes operands held by the caller only at start
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module mdc_divider (
    input  wire logic mclk,
    input  wire logic rst_n,
    mdc_div_if.div    dv
);

    logic [15:0] quo_ff,  nxt_quo;
    logic [15:0] rem_ff,  nxt_rem;
    logic [15:0] dsr_ff,  nxt_dsr;
    logic [4:0]  step_ff, nxt_step;
    logic        done_ff, nxt_done;
    logic [16:0] trial;

    // ****************************************
    // Shift-subtract step
    // ****************************************
    always_comb begin
        nxt_quo  = quo_ff;
        nxt_rem  = rem_ff;
        nxt_dsr  = dsr_ff;
        nxt_step = step_ff;
        nxt_done = 1'b0;
        trial    = {rem_ff, quo_ff[15]} - {1'b0, dsr_ff};
        if (dv.start && step_ff == `MDC_STEP_RST) begin
            nxt_quo  = dv.dividend;
            nxt_rem  = `MDC_HALF_ZERO;
            nxt_dsr  = dv.divisor;
            nxt_step = `MDC_DIV_STEPS;
        end else if (step_ff != `MDC_STEP_RST) begin
            nxt_step = step_ff - `MDC_STEP_ONE;
            if (trial[16]) begin // Remainder too small, keep it
                nxt_rem = {rem_ff[14:0], quo_ff[15]};
                nxt_quo = {quo_ff[14:0], 1'b0};
            end else begin
                nxt_rem = trial[15:0];
                nxt_quo = {quo_ff[14:0], 1'b1};
            end
            nxt_done = (step_ff == `MDC_STEP_ONE);
        end
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            quo_ff  <= `MDC_HALF_ZERO;
            rem_ff  <= `MDC_HALF_ZERO;
            dsr_ff  <= `MDC_HALF_ZERO;
            step_ff <= `MDC_STEP_RST;
            done_ff <= 1'b0;
        end else begin
            quo_ff  <= nxt_quo;
            rem_ff  <= nxt_rem;
            dsr_ff  <= nxt_dsr;
            step_ff <= nxt_step;
            done_ff <= nxt_done;
        end
    end

    assign dv.busy = (step_ff != `MDC_STEP_RST);
    assign dv.done = done_ff;
    assign dv.quot = quo_ff;
    assign dv.rem  = rem_ff;

endmodule : mdc_divider

`default_nettype wire

// ===== verilog/mdc_top.sv
// Multiplier/divider/MAC coprocessor beside a 16-bit CPU core
// Assumes operands valid in the request cycle and the core waiting while busy is high
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module mdc_top (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        mode_wr,
    input  wire logic [15:0] mode_data,
    input  wire logic        op_req,
    input  wire logic [15:0] op_a,
    input  wire logic [15:0] op_b,
    input  wire logic        preload_req,
    input  wire logic [15:0] preload_hi,
    input  wire logic [15:0] preload_lo,
    output logic      [15:0] result_out,
    output logic             result_valid,
    output logic             busy,
    output logic             flag_c,
    output logic             flag_v,
    output logic             flag_z,
    output logic             flag_n
);

    // ****************************************
    // Link to the divider
    // ****************************************
    mdc_div_if dvi ();

    // ****************************************
    // State registers and their next values
    // ****************************************
    logic [6:0]          mode_ff;
    logic [6:0]          nxt_mode;
    logic [31:0]         res_ff;
    logic [31:0]         nxt_res;
    mdc_pkg::mdc_state_t st_ff;
    mdc_pkg::mdc_state_t nxt_st;
    logic                neg_q_ff;
    logic                nxt_neg_q;
    logic                neg_r_ff;
    logic                nxt_neg_r;
    logic [15:0]         out_ff;
    logic [15:0]         nxt_out;
    logic                val_ff;
    logic                nxt_val;
    logic                busy_ff;
    logic                nxt_busy;
    logic [3:0]          flg_ff;
    logic [3:0]          nxt_flg;

    // ****************************************
    // Combinational datapath signals
    // ****************************************
    logic                start_c;    // Divider launch strobe
    logic [15:0]         dvd_c;      // Dividend magnitude
    logic [15:0]         dvs_c;      // Divisor magnitude
    logic [3:0]          op_c;       // Operation field of the mode
    logic [2:0]          om_c;       // Output field of the mode
    logic [6:0]          mode_in_c;  // Mode field of a write
    logic [31:0]         prod_u;     // Unsigned product
    logic [31:0]         prod_s;     // Signed product
    logic [31:0]         sum_s;      // Accumulated sum
    logic [15:0]         q_c;        // Quotient with sign applied
    logic [15:0]         r_c;        // Residue with sign applied

    // ****************************************
    // Helper functions
    // ****************************************
    // Pick the half requested by the output mode
    function automatic logic [15:0] pick_half(input logic [2:0]  om,
                                              input logic [31:0] v);
        pick_half = (om == `MDC_OUT_HIGH) ? v[31:16] : v[15:0];
    endfunction : pick_half

    // Magnitude of a 16-bit value, signed or plain
    function automatic logic [15:0] mag16(input logic sgn,
                                          input logic [15:0] v);
        mag16 = (sgn && v[15]) ? 16'(-v) : v;
    endfunction : mag16

    // Signed division selected by the operation field
    function automatic logic is_sdiv(input logic [3:0] op);
        is_sdiv = (op == `MDC_OP_SDIV);
    endfunction : is_sdiv

    // ****************************************
    // Arithmetic datapath
    // ****************************************
    // Mode fields and the field of an incoming write
    always_comb begin
        op_c      = mode_ff[`MDC_OP_MSB:`MDC_OP_LSB];
        om_c      = mode_ff[`MDC_OUT_MSB:`MDC_OUT_LSB];
        mode_in_c = mode_data[`MDC_OUT_MSB:`MDC_OP_LSB];
    end

    // Both products every cycle; the operation picks one
    always_comb begin
        prod_u = op_a * op_b;
        prod_s = 32'($signed(op_a) * $signed(op_b));
        sum_s  = prod_s + res_ff;
    end

    // Divider sees magnitudes; signs go back on afterwards
    always_comb begin
        dvd_c = mag16(is_sdiv(op_c), op_a);
        dvs_c = mag16(is_sdiv(op_c), op_b);
        q_c   = neg_q_ff ? 16'(-dvi.quot) : dvi.quot;
        r_c   = neg_r_ff ? 16'(-dvi.rem) : dvi.rem;
    end

    // ****************************************
    // Control, mode and result registers
    // ****************************************
    always_comb begin
        nxt_mode  = mode_ff;
        nxt_res   = res_ff;
        nxt_st    = st_ff;
        nxt_neg_q = neg_q_ff;
        nxt_neg_r = neg_r_ff;
        nxt_out   = out_ff;
        nxt_val   = 1'b0;
        nxt_busy  = busy_ff;
        nxt_flg   = flg_ff;
        start_c   = 1'b0;
        case (st_ff)
            mdc_pkg::MDC_IDLE: begin
                // Mode write beats preload, preload beats operate
                if (mode_wr) begin
                    nxt_mode = mode_in_c;
                    // Operation field 0 clears the result at once
                    if (mode_in_c[`MDC_OP_MSB:`MDC_OP_LSB] == `MDC_OP_CLEAR)
                        nxt_res = `MDC_RES_RST;
                end else if (preload_req) begin
                    // Preload only acts in the two load modes
                    if (op_c == `MDC_OP_LOAD16)
                        nxt_res = {`MDC_HALF_ZERO, preload_lo};
                    else if (op_c == `MDC_OP_LOAD32)
                        nxt_res = {preload_hi, preload_lo};
                end else if (op_req) begin
                    // Each direct answer clears the flags first
                    nxt_val = 1'b1;
                    nxt_flg = 4'h0;
                    case (op_c)
                        // Plain product, kept for readback
                        `MDC_OP_UMUL: begin
                            nxt_res = prod_u;
                            nxt_out = pick_half(om_c, prod_u);
                        end
                        // Two's complement product
                        `MDC_OP_SMUL: begin
                            nxt_res = prod_s;
                            nxt_out = pick_half(om_c, prod_s);
                        end
                        // Accumulate onto the stored result
                        `MDC_OP_SMAC: begin
                            nxt_res = sum_s;
                            nxt_out = pick_half(om_c, sum_s);
                            // Overflow when like signs give an unlike sum
                            nxt_flg[1] = (prod_s[31] == res_ff[31]) &&
                                         (sum_s[31] != res_ff[31]);
                        end
                        // Divide launch; flags stay until the answer
                        `MDC_OP_UDIV, `MDC_OP_SDIV: begin
                            nxt_val   = 1'b0;
                            nxt_flg   = flg_ff;
                            start_c   = 1'b1;
                            nxt_busy  = 1'b1;
                            nxt_neg_q = is_sdiv(op_c) &&
                                        (op_a[15] ^ op_b[15]);
                            nxt_neg_r = is_sdiv(op_c) && op_a[15];
                            nxt_st    = mdc_pkg::MDC_DIV;
                        end
                        // Read mode and reserved codes return a stored half
                        default: begin
                            nxt_out = pick_half(om_c, res_ff);
                        end
                    endcase
                end
            end
            // Requests are ignored until the divider finishes
            mdc_pkg::MDC_DIV: begin
                if (dvi.done && !dvi.busy)
                    nxt_st = mdc_pkg::MDC_FIX;
            end
            // Signs go back on; quotient low, residue high
            mdc_pkg::MDC_FIX: begin
                nxt_res = {r_c, q_c};
                nxt_st  = mdc_pkg::MDC_DONE;
            end
            // Present the chosen half and release busy
            mdc_pkg::MDC_DONE: begin
                nxt_out  = pick_half(om_c, res_ff);
                nxt_val  = 1'b1;
                nxt_busy = 1'b0;
                nxt_flg  = 4'h0;
                nxt_st   = mdc_pkg::MDC_IDLE;
            end
            // Unused state code falls back to idle
            default: begin
                nxt_st   = mdc_pkg::MDC_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Control state registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff    <= mdc_pkg::MDC_IDLE;
            neg_q_ff <= 1'b0;
            neg_r_ff <= 1'b0;
            busy_ff  <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            neg_q_ff <= nxt_neg_q;
            neg_r_ff <= nxt_neg_r;
            busy_ff  <= nxt_busy;
        end
    end

    // ****************************************
    // Mode register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_ff <= `MDC_MODE_RST;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ****************************************
    // Result register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_ff <= `MDC_RES_RST;
        end else begin
            res_ff <= nxt_res;
        end
    end

    // ****************************************
    // Answer registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_ff <= `MDC_HALF_ZERO;
            val_ff <= 1'b0;
            flg_ff <= 4'h0;
        end else begin
            out_ff <= nxt_out;
            val_ff <= nxt_val;
            flg_ff <= nxt_flg;
        end
    end

    // ****************************************
    // Divider hookup
    // ****************************************
    // Operands only matter in the launch cycle
    assign dvi.start    = start_c;
    assign dvi.dividend = dvd_c;
    assign dvi.divisor  = dvs_c;

    mdc_divider u_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .dv    (dvi.div)
    );

    // ****************************************
    // Outputs
    // ****************************************
    // Outputs straight from flops; flags order C,V,Z,N in flg_ff[0..3]
    assign result_out   = out_ff;
    assign result_valid = val_ff;
    assign busy         = busy_ff;
    assign flag_c       = flg_ff[0];
    assign flag_v       = flg_ff[1];
    assign flag_z       = flg_ff[2];
    assign flag_n       = flg_ff[3];

endmodule : mdc_top

`default_nettype wire

// ===== verification/mdc_checker.sv
// Assertion checker on the coprocessor top ports
// Assumes one clock domain and a bind onto mdc_top
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module mdc_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        mode_wr,
    input wire logic [15:0] mode_data,
    input wire logic        op_req,
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    input wire logic        preload_req,
    input wire logic [15:0] result_out,
    input wire logic        result_valid,
    input wire logic        busy,
    input wire logic        flag_c,
    input wire logic        flag_v,
    input wire logic        flag_z,
    input wire logic        flag_n
);
    logic        [6:0]  mode_ff;
    logic        [6:0]  nxt_mode;
    logic        [3:0]  opc;
    logic               take;
    logic               dv;
    logic signed [31:0] sprod;
    logic        [31:0] uprod;
    logic        [15:0] mul_h;
    logic        [15:0] div_h;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Mode as the unit takes it; writes while busy are dropped
    always_comb begin
        nxt_mode = mode_ff;
        if (!rst_n)
            nxt_mode = `MDC_MODE_RST;
        else if (mode_wr && !busy)
            nxt_mode = mode_data[6:0];
    end
    always_ff @(posedge mclk) begin
        mode_ff <= nxt_mode;
    end

    // Expected halves for the request taken in this cycle
    assign opc   = mode_ff[3:0];
    assign take  = op_req && !mode_wr && !preload_req && !busy;
    assign dv    = opc == `MDC_OP_UDIV || opc == `MDC_OP_SDIV;
    assign sprod = $signed(op_a) * $signed(op_b);
    assign uprod = op_a * op_b;
    assign mul_h = mode_ff[4] ? (opc[0] ? sprod[31:16] : uprod[31:16])
                              : (opc[0] ? sprod[15:0] : uprod[15:0]);
    assign div_h = mode_ff[4] ? op_a % op_b : op_a / op_b;

    property p_mul;
        take && (opc == `MDC_OP_UMUL || opc == `MDC_OP_SMUL) |=>
            result_valid && !busy && result_out == $past(mul_h);
    endproperty
    a_mul: assert property (p_mul)
        else $error("multiply answer wrong or late");
    property p_div_time;
        take && dv |=> (busy && !result_valid)[*8] ##12
            (result_valid && !busy);
    endproperty
    a_div_time: assert property (p_div_time)
        else $error("divide timing wrong");
    property p_udiv;
        take && opc == `MDC_OP_UDIV && op_b != 16'h0000 |=>
            ##19 result_out == $past(div_h, 20);
    endproperty
    a_udiv: assert property (p_udiv)
        else $error("unsigned divide answer wrong");
    property p_busy_quiet;
        busy |-> !result_valid;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("answer while busy");
    property p_hold_out;
        !result_valid |-> $stable(result_out);
    endproperty
    a_hold_out: assert property (p_hold_out)
        else $error("result changed without answer");
    property p_flag_hold;
        !result_valid |-> $stable({flag_c, flag_v, flag_z, flag_n});
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flags changed without answer");
    property p_flag_zero;
        result_valid |-> !flag_c && !flag_z && !flag_n;
    endproperty
    a_flag_zero: assert property (p_flag_zero)
        else $error("carry, zero or sign flag set");
    property p_flag_v;
        take && !dv && opc != `MDC_OP_SMAC |=> !flag_v;
    endproperty
    a_flag_v: assert property (p_flag_v)
        else $error("overflow flag outside accumulate");
endmodule : mdc_checker

bind mdc_top mdc_checker u_chk (.mclk, .rst_n, .mode_wr, .mode_data,
    .op_req, .op_a, .op_b, .preload_req, .result_out, .result_valid,
    .busy, .flag_c, .flag_v, .flag_z, .flag_n);

`default_nettype wire

// ===== verification/mdc_core_model.sv
// Core-side model issuing coprocessor instructions
// Assumes the bench calls its tasks; drives on falling edges
`timescale 1ns/100ps
`default_nettype none

module mdc_core_model (
    input  wire logic        mclk,
    output var  logic        mode_wr,
    output var  logic [15:0] mode_data,
    output var  logic        op_req,
    output var  logic [15:0] op_a,
    output var  logic [15:0] op_b,
    output var  logic        preload_req,
    output var  logic [15:0] preload_hi,
    output var  logic [15:0] preload_lo
);
    // Quiet bus at time zero
    initial begin
        {mode_wr, op_req, preload_req} = 3'h0;
        {mode_data, op_a, op_b} = 48'h0;
        {preload_hi, preload_lo} = 32'h0;
    end

    // Mode write, one-cycle strobe; released data is inverted
    task automatic wr_mode(input logic [15:0] d);
        @(negedge mclk);
        mode_wr = 1'b1;
        mode_data = d;
        @(negedge mclk);
        mode_wr = 1'b0;
        mode_data = ~d;
    endtask : wr_mode

    // Operate instruction carrying both operands
    task automatic operate(input logic [15:0] a, input logic [15:0] b);
        @(negedge mclk);
        op_req = 1'b1;
        {op_a, op_b} = {a, b};
        @(negedge mclk);
        op_req = 1'b0;
        {op_a, op_b} = ~{a, b};
    endtask : operate

    // Preload instruction with upper and lower words
    task automatic preload(input logic [15:0] hi, input logic [15:0] lo);
        @(negedge mclk);
        preload_req = 1'b1;
        {preload_hi, preload_lo} = {hi, lo};
        @(negedge mclk);
        preload_req = 1'b0;
        {preload_hi, preload_lo} = ~{hi, lo};
    endtask : preload
endmodule : mdc_core_model

`default_nettype wire

// ===== verification/mdc_top_tb.sv
// Self-checking bench for the coprocessor
// Assumes mdc_core_model drives the core side of mdc_top
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module mdc_top_tb;
    logic        mclk, rst_n, mode_wr, op_req, preload_req;
    logic [15:0] mode_data, op_a, op_b, preload_hi, preload_lo;
    logic [15:0] result_out, a, b;
    logic        result_valid, busy, flag_c, flag_v, flag_z, flag_n;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic [31:0] res, seed;
    logic [6:0]  mode;
    logic [6:0]  mtab[8] = '{7'h04, 7'h14, 7'h05, 7'h15,
                             7'h08, 7'h18, 7'h09, 7'h19};
    int          errors, n_tests;

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    mdc_top DUT (.mclk(mclk), .rst_n(rst_n), .mode_wr(mode_wr),
        .mode_data(mode_data), .op_req(op_req), .op_a(op_a), .op_b(op_b),
        .preload_req(preload_req), .preload_hi(preload_hi),
        .preload_lo(preload_lo), .result_out(result_out),
        .result_valid(result_valid), .busy(busy), .flag_c(flag_c),
        .flag_v(flag_v), .flag_z(flag_z), .flag_n(flag_n));
    mdc_core_model core (.mclk(mclk), .mode_wr(mode_wr),
        .mode_data(mode_data), .op_req(op_req), .op_a(op_a), .op_b(op_b),
        .preload_req(preload_req), .preload_hi(preload_hi),
        .preload_lo(preload_lo));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic give_verdict();
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // Mode write with random junk above bit 6
    task automatic set_mode(input logic [6:0] m);
        seed = lfsr(seed);
        core.wr_mode({seed[24:16], m});
        mode = m;
        if (m[3:0] == `MDC_OP_CLEAR)
            res = 32'h0;
    endtask : set_mode

    task automatic pre(input logic [15:0] hi, input logic [15:0] lo);
        core.preload(hi, lo);
        res = (mode[3:0] == `MDC_OP_LOAD16) ? {16'h0, lo} : {hi, lo};
    endtask : pre

    // Operate: note expected half and flag, then issue and wait
    task automatic op(input logic [15:0] x, input logic [15:0] y,
                      input logic intr);
        logic signed [32:0] s;
        logic [15:0] q;
        logic [15:0] r;
        logic v;
        int k;
        v = 1'b0;
        q = 16'h0;
        r = 16'h0;
        case (mode[3:0])
            `MDC_OP_UMUL: res = x * y;
            `MDC_OP_SMUL: res = $signed(x) * $signed(y);
            `MDC_OP_SMAC: begin
                s = $signed({res[31], res}) + $signed(x) * $signed(y);
                v = s[32] ^ s[31];
                res = s[31:0];
            end
            `MDC_OP_UDIV: res = (y == 16'h0) ? {x, 16'hffff}
                                             : {x % y, x / y};
            `MDC_OP_SDIV: begin
                q = $signed(x) / $signed(y);
                r = $signed(x) % $signed(y);
                res = {r, q};
            end
            default: ;
        endcase
        exp_q.push_back({v, mode[4] ? res[31:16] : res[15:0]});
        core.operate(x, y);
        if (intr)
            core.wr_mode(16'h0010);
        @(negedge mclk);
        for (k = 0; k < 40 && busy !== 1'b0; k++)
            @(negedge mclk);
        if (k == 40) begin
            errors++;
            give_verdict();
        end
    endtask : op

    // Oldest note against each answer
    always @(posedge mclk) begin
        if (rst_n === 1'b1 && result_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h0dead;
            n_tests++;
            if ({flag_v, result_out} !== e) begin
                errors++;
                $display("mismatch result_out expected %h seen %h",
                         e, {flag_v, result_out});
            end
        end
    end

    // Main sequence
    initial begin
        {errors, n_tests} = 0;
        {res, mode} = 39'h0;
        seed = 32'h9d93;
        rst_n = 1'b0;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        set_mode(7'h13);
        op(16'h0, 16'h0, 1'b0);
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            {a, b} = seed;
            if (b == 16'h0 || b == 16'hffff)
                b = 16'h0003;
            set_mode(mtab[i % 8]);
            op(a, b, 1'b0);
            set_mode({2'b00, ~mtab[i % 8][4], 4'h3});
            op(b, a, 1'b0);
        end
        set_mode(7'h01);
        pre(16'hbeef, 16'h1234);
        set_mode(7'h13);
        op(a, b, 1'b0);
        set_mode(7'h02);
        pre(16'h7fff, 16'hffff);
        set_mode(7'h17);
        op(16'h0001, 16'h0001, 1'b0);
        op(16'hffff, 16'h0002, 1'b0);
        op(16'h0001, 16'h0001, 1'b0);
        set_mode(7'h10);
        set_mode(7'h03);
        op(a, b, 1'b0);
        set_mode(7'h08);
        op(16'h1234, 16'h0000, 1'b0);
        set_mode(7'h18);
        op(16'h0064, 16'h0007, 1'b1);
        op(16'h0065, 16'h0007, 1'b0);
        repeat (4) @(negedge mclk);
        if (exp_q.size() != 0) begin
            errors++;
            $display("mismatch answers expected 0 seen %0d", exp_q.size());
        end
        give_verdict();
    end
endmodule : mdc_top_tb

`default_nettype wire
